// ==== aesc_pkg.sv ====
// What this block does
// - electronics mask bits: drive current, drive signal, memories, processors, timeout, defaults.
// - sensor mask bits: travel, port A, port B, supply, temperature sensors.
// - environment mask bits: supply high/low, temperature high/low; bit 1 clear at reset.
// - every alert mask is a 32-bit read/write word; one enables, zero disables.
// - proximity mask: open, closed, high high, high, low, low low; resets zero.
// - travel history mask: cycle counter bit 0, accumulator bit 1; reset zero.
// - trigger bit one forces zero drive on that alert, zero keeps control.
// - shutdown trigger bits 0 to 6 map causes; bits 7 to 31 reserved.
// - recovery bit zero recovers automatically, one waits; bit 0 reserved.
// - setpoint timeout settable 0 to 800 seconds, default 600.
// - drive deviation limit accepts 5 to 100 percent, default 25.
// - drive deviation time settable 0.25 to 120 seconds, default 5.
// - read-only status records shutdown causes whenever the trigger bit is set.
// - manual recovery keeps cause bits; writing block mode target clears all whose triggered cause is no longer present.
package aesc_pkg;
  localparam logic [7:0] ELEC_OFS    = 8'h00;
  localparam logic [7:0] SENS_OFS    = 8'h04;
  localparam logic [7:0] ENV_OFS     = 8'h08;
  localparam logic [7:0] TRAV_OFS    = 8'h0C;
  localparam logic [7:0] PROX_OFS    = 8'h10;
  localparam logic [7:0] HIST_OFS    = 8'h14;
  localparam logic [7:0] PERF_OFS    = 8'h18;
  localparam logic [7:0] SDTRIG_OFS  = 8'h1C;
  localparam logic [7:0] SDREC_OFS   = 8'h20;
  localparam logic [7:0] SPTO_OFS    = 8'h24;
  localparam logic [7:0] DDLIM_OFS   = 8'h28;
  localparam logic [7:0] DDTIME_OFS  = 8'h2C;
  localparam logic [7:0] SDSTAT_OFS  = 8'h30;
  localparam logic [7:0] MODE_OFS    = 8'h34;
  localparam logic [7:0] IRQST_OFS   = 8'h38;
  localparam logic [7:0] IRQMSK_OFS  = 8'h3C;

  localparam logic [31:0] ELEC_RST   = 32'h0000_00BF;
  localparam logic [31:0] SENS_RST   = 32'h0000_001F;
  localparam logic [31:0] ENV_RST    = 32'h0000_000D;
  localparam logic [31:0] TRAV_RST   = 32'h0000_0001;
  localparam logic [31:0] PROX_RST   = 32'h0000_0000;
  localparam logic [31:0] HIST_RST   = 32'h0000_0000;
  localparam logic [31:0] PERF_RST   = 32'h0000_0003;
  localparam logic [31:0] SDTRIG_RST = 32'h0000_0000;
  localparam logic [31:0] SDREC_RST  = 32'h0000_0000;
  localparam logic [31:0] SD_VALID   = 32'h0000_007F;
  localparam logic [31:0] REC_VALID  = 32'h0000_007E;

  // times held in milliseconds, limit in percent
  localparam logic [31:0] SPTO_MAX_MS  = 32'd800000;
  localparam logic [31:0] SPTO_RST_MS  = 32'd600000;
  localparam logic [31:0] DDLIM_MIN    = 32'd5;
  localparam logic [31:0] DDLIM_MAX    = 32'd100;
  localparam logic [31:0] DDLIM_RST    = 32'd25;
  localparam logic [31:0] DDT_MIN_MS   = 32'd250;
  localparam logic [31:0] DDT_MAX_MS   = 32'd120000;
  localparam logic [31:0] DDT_RST_MS   = 32'd5000;
  localparam int          CLK_MHZ      = 100;
  localparam int          MS_CYCLES    = CLK_MHZ * 1000;

  // electronics mask bit positions
  localparam int E_DRV_CUR = 0;
  localparam int E_OB_TO   = 6;
  // shutdown cause bit positions
  localparam int S_DRV_CUR = 0;
  localparam int S_OB_TO   = 6;
  localparam int NCAUSE    = 7;

  localparam int IRQ_DRV   = 0;
  localparam int IRQ_TO    = 1;
  localparam int IRQ_SD    = 2;

  typedef struct packed {
    logic [NCAUSE-1:0] cond;
    logic              setpoint_upd;
    logic [6:0]        deviation_pct;
  } aesc_in_t;

  typedef enum logic [1:0] {RESP_OKAY = 2'b00, RESP_SLVERR = 2'b10} aesc_resp_t;
endpackage : aesc_pkg

// ==== aesc_top.sv ====
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
module aesc_top
  import aesc_pkg::*;
#(
  parameter int MS_DIV = MS_CYCLES
) (
  input  wire logic        sys_clk_i,       // 100 MHz
  input  wire logic        sys_rst_i,       // async, high
  input  wire logic [7:0]  s_axi_awaddr,    // write address
  input  wire logic        s_axi_awvalid,   // write address valid
  output logic             s_axi_awready,   // write address ready
  input  wire logic [31:0] s_axi_wdata,     // write data
  input  wire logic [3:0]  s_axi_wstrb,     // byte enables
  input  wire logic        s_axi_wvalid,    // write data valid
  output logic             s_axi_wready,    // write data ready
  output logic [1:0]       s_axi_bresp,     // write response
  output logic             s_axi_bvalid,    // write response valid
  input  wire logic        s_axi_bready,    // write response ready
  input  wire logic [7:0]  s_axi_araddr,    // read address
  input  wire logic        s_axi_arvalid,   // read address valid
  output logic             s_axi_arready,   // read address ready
  output logic [31:0]      s_axi_rdata,     // read data
  output logic [1:0]       s_axi_rresp,     // read response
  output logic             s_axi_rvalid,    // read data valid
  input  wire logic        s_axi_rready,    // read data ready
  input  wire aesc_in_t    dev_i,           // alert conditions and setpoint strobe
  output logic             zero_drive_o,    // force zero drive
  output logic [31:0]      shutdown_cause_o,// latched shutdown causes
  output logic             drive_alert_o,   // drive current alert
  output logic             timeout_alert_o, // setpoint timeout alert
  output logic             irq_o            // level interrupt
);

  logic [31:0] elec_q, sens_q, env_q, trav_q, prox_q, hist_q, perf_q;
  logic [31:0] sdtrig_q, sdrec_q, spto_q, ddlim_q, ddtime_q;
  logic [31:0] sdstat_q, irqst_q, irqmsk_q;
  logic [7:0]  awaddr_q, araddr_q;
  logic        aw_have_q, w_have_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_go, wr_ok, wr_mode;
  logic [16:0] ms_cnt_q;
  logic        ms_tick;
  logic [31:0] to_ms_q, dd_ms_q;
  logic        drv_ev, to_ev;
  logic [NCAUSE-1:0] cond_all;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo,
                                        input logic [31:0] hi);
    if (v < lo) begin
      return lo;
    end else if (v > hi) begin
      return hi;
    end else begin
      return v;
    end
  endfunction : clamp

  // write channel: address and data taken in either order
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
      s_axi_wready  <= !w_have_q && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign wr_go   = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_ok   = (awaddr_q[1:0] == 2'b00) && (awaddr_q <= IRQMSK_OFS) && (awaddr_q != SDSTAT_OFS);
  assign wr_mode = wr_go && (awaddr_q == MODE_OFS);

  // alert masks, read/write in every mode
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      elec_q   <= ELEC_RST;
      sens_q   <= SENS_RST;
      env_q    <= ENV_RST;
      trav_q   <= TRAV_RST;
      prox_q   <= PROX_RST;
      hist_q   <= HIST_RST;
      perf_q   <= PERF_RST;
      irqmsk_q <= 32'h0000_0000;
    end else if (wr_go) begin
      if (awaddr_q == ELEC_OFS) begin
        elec_q <= merge(elec_q, wdata_q, wstrb_q);
      end else if (awaddr_q == SENS_OFS) begin
        sens_q <= merge(sens_q, wdata_q, wstrb_q);
      end else if (awaddr_q == ENV_OFS) begin
        env_q <= merge(env_q, wdata_q, wstrb_q);
      end else if (awaddr_q == TRAV_OFS) begin
        trav_q <= merge(trav_q, wdata_q, wstrb_q);
      end else if (awaddr_q == PROX_OFS) begin
        prox_q <= merge(prox_q, wdata_q, wstrb_q);
      end else if (awaddr_q == HIST_OFS) begin
        hist_q <= merge(hist_q, wdata_q, wstrb_q);
      end else if (awaddr_q == PERF_OFS) begin
        perf_q <= merge(perf_q, wdata_q, wstrb_q);
      end else if (awaddr_q == IRQMSK_OFS) begin
        irqmsk_q <= merge(irqmsk_q, wdata_q, wstrb_q);
      end
    end
  end

  // shutdown config and timer settings; reserved config bits read zero, out-of-range timer values clamp
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sdtrig_q <= SDTRIG_RST;
      sdrec_q  <= SDREC_RST;
      spto_q   <= SPTO_RST_MS;
      ddlim_q  <= DDLIM_RST;
      ddtime_q <= DDT_RST_MS;
    end else if (wr_go) begin
      if (awaddr_q == SDTRIG_OFS) begin
        sdtrig_q <= merge(sdtrig_q, wdata_q, wstrb_q) & SD_VALID;
      end else if (awaddr_q == SDREC_OFS) begin
        sdrec_q <= merge(sdrec_q, wdata_q, wstrb_q) & REC_VALID;
      end else if (awaddr_q == SPTO_OFS) begin
        spto_q <= clamp(merge(spto_q, wdata_q, wstrb_q), 32'd0, SPTO_MAX_MS);
      end else if (awaddr_q == DDLIM_OFS) begin
        ddlim_q <= clamp(merge(ddlim_q, wdata_q, wstrb_q), DDLIM_MIN, DDLIM_MAX);
      end else if (awaddr_q == DDTIME_OFS) begin
        ddtime_q <= clamp(merge(ddtime_q, wdata_q, wstrb_q), DDT_MIN_MS, DDT_MAX_MS);
      end
    end
  end

  // millisecond tick keeps timer counters narrow
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ms_cnt_q <= 17'd0;
    end else if (ms_cnt_q == 17'(MS_DIV - 1)) begin
      ms_cnt_q <= 17'd0;
    end else begin
      ms_cnt_q <= ms_cnt_q + 17'd1;
    end
  end
  assign ms_tick = (ms_cnt_q == 17'(MS_DIV - 1));

  // drive deviation must persist for as many millisecond ticks as the alert time
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dd_ms_q       <= 32'd0;
      drive_alert_o <= 1'b0;
    end else begin
      if ({25'd0, dev_i.deviation_pct} <= ddlim_q) begin
        dd_ms_q       <= 32'd0;
        drive_alert_o <= 1'b0;
      end else if (dd_ms_q >= ddtime_q) begin
        drive_alert_o <= elec_q[E_DRV_CUR];
      end else if (ms_tick) begin
        dd_ms_q <= dd_ms_q + 32'd1;
      end
    end
  end
  assign drv_ev = drive_alert_o;

  // setpoint update watchdog
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      to_ms_q         <= 32'd0;
      timeout_alert_o <= 1'b0;
    end else if (dev_i.setpoint_upd) begin
      to_ms_q         <= 32'd0;
      timeout_alert_o <= 1'b0;
    end else if (to_ms_q >= spto_q) begin
      timeout_alert_o <= elec_q[E_OB_TO];
    end else if (ms_tick) begin
      to_ms_q <= to_ms_q + 32'd1;
    end
  end
  assign to_ev = timeout_alert_o;

  always_comb begin
    cond_all            = dev_i.cond;
    cond_all[S_DRV_CUR] = dev_i.cond[S_DRV_CUR] | drv_ev;
    cond_all[S_OB_TO]   = dev_i.cond[S_OB_TO] | to_ev;
  end

  // causes latch while triggered; auto-recovery drops them when clear
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sdstat_q <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < NCAUSE; i++) begin
        if (sdtrig_q[i] && cond_all[i]) begin
          sdstat_q[i] <= 1'b1;
        end else if (wr_mode) begin
          sdstat_q[i] <= 1'b0;
        end else if (!sdrec_q[i] || !sdtrig_q[i]) begin
          sdstat_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      zero_drive_o     <= 1'b0;
      shutdown_cause_o <= 32'h0000_0000;
    end else begin
      zero_drive_o     <= |sdstat_q;
      shutdown_cause_o <= sdstat_q;
    end
  end

  // sticky interrupt status, write one to clear, set wins
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irqst_q <= 32'h0000_0000;
      irq_o   <= 1'b0;
    end else begin
      for (int i = 0; i < 32; i++) begin
        if ((i == IRQ_DRV && drv_ev) || (i == IRQ_TO && to_ev) || (i == IRQ_SD && |sdstat_q)) begin
          irqst_q[i] <= 1'b1;
        end else if (wr_go && awaddr_q == IRQST_OFS && wstrb_q[i/8] && wdata_q[i]) begin
          irqst_q[i] <= 1'b0;
        end
      end
      irq_o <= |(irqst_q & irqmsk_q);
    end
  end

  // read channel
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
      araddr_q      <= 8'h00;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        araddr_q     <= s_axi_araddr;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        if (s_axi_araddr == ELEC_OFS) begin
          s_axi_rdata <= elec_q;
        end else if (s_axi_araddr == SENS_OFS) begin
          s_axi_rdata <= sens_q;
        end else if (s_axi_araddr == ENV_OFS) begin
          s_axi_rdata <= env_q;
        end else if (s_axi_araddr == TRAV_OFS) begin
          s_axi_rdata <= trav_q;
        end else if (s_axi_araddr == PROX_OFS) begin
          s_axi_rdata <= prox_q;
        end else if (s_axi_araddr == HIST_OFS) begin
          s_axi_rdata <= hist_q;
        end else if (s_axi_araddr == PERF_OFS) begin
          s_axi_rdata <= perf_q;
        end else if (s_axi_araddr == SDTRIG_OFS) begin
          s_axi_rdata <= sdtrig_q;
        end else if (s_axi_araddr == SDREC_OFS) begin
          s_axi_rdata <= sdrec_q;
        end else if (s_axi_araddr == SPTO_OFS) begin
          s_axi_rdata <= spto_q;
        end else if (s_axi_araddr == DDLIM_OFS) begin
          s_axi_rdata <= ddlim_q;
        end else if (s_axi_araddr == DDTIME_OFS) begin
          s_axi_rdata <= ddtime_q;
        end else if (s_axi_araddr == SDSTAT_OFS) begin
          s_axi_rdata <= sdstat_q;
        end else if (s_axi_araddr == MODE_OFS) begin
          s_axi_rdata <= 32'h0000_0000;
        end else if (s_axi_araddr == IRQST_OFS) begin
          s_axi_rdata <= irqst_q;
        end else if (s_axi_araddr == IRQMSK_OFS) begin
          s_axi_rdata <= irqmsk_q;
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : aesc_top

// ==== aesc_props.sv ====
module aesc_props
  import aesc_pkg::*;
#(
  parameter int MS_DIV = MS_CYCLES
) (
  input wire logic        sys_clk_i,        // clock
  input wire logic        sys_rst_i,        // reset
  input wire logic [1:0]  s_axi_bresp,      // b resp
  input wire logic        s_axi_bvalid,     // b valid
  input wire logic        s_axi_bready,     // b ready
  input wire logic [31:0] s_axi_rdata,      // r data
  input wire logic [1:0]  s_axi_rresp,      // r resp
  input wire logic        s_axi_rvalid,     // r valid
  input wire aesc_in_t    dev_i,            // conditions
  input wire logic        zero_drive_o,     // zero drive
  input wire logic [31:0] shutdown_cause_o, // causes
  input wire logic        drive_alert_o,    // drive alert
  input wire logic        timeout_alert_o   // timeout alert
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [31:0] hi_cnt_q;
  // cycles above the lowest settable limit; any drive alert needs at least the minimum time less one millisecond
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) hi_cnt_q <= 32'h0;
    else if (dev_i.deviation_pct <= 7'h05) hi_cnt_q <= 32'h0;
    else if (hi_cnt_q != 32'hFFFF_FFFF) hi_cnt_q <= hi_cnt_q + 32'h1;
  end
  reserved_causes_a: assert property (shutdown_cause_o[31:7] == 25'h0)
    else $error("reserved shutdown cause bit set");
  zero_drive_on_a: assert property ($rose(|shutdown_cause_o) |-> ##[0:1] zero_drive_o)
    else $error("shutdown cause without zero drive");
  zero_drive_off_a: assert property ((shutdown_cause_o == 32'h0) [*3] |-> !zero_drive_o)
    else $error("zero drive with no cause");
  drive_quiet_a: assert property ((dev_i.deviation_pct <= 7'h05) [*4] |-> !drive_alert_o)
    else $error("drive alert without deviation");
  drive_persist_a: assert property ($rose(drive_alert_o) |-> hi_cnt_q >= (DDT_MIN_MS - 32'h1) * MS_DIV)
    else $error("drive alert too early");
  timeout_fresh_a: assert property ($rose(timeout_alert_o) |-> !$past(dev_i.setpoint_upd))
    else $error("timeout alert right after update");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  error_data_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read returned data");
  shutdown_c: cover property ($rose(zero_drive_o));
  drive_c: cover property ($rose(drive_alert_o));
  timeout_c: cover property ($rose(timeout_alert_o));
endmodule : aesc_props

bind aesc_top aesc_props #(.MS_DIV(MS_DIV)) u_props (
  .sys_clk_i        (sys_clk_i),
  .sys_rst_i        (sys_rst_i),
  .s_axi_bresp      (s_axi_bresp),
  .s_axi_bvalid     (s_axi_bvalid),
  .s_axi_bready     (s_axi_bready),
  .s_axi_rdata      (s_axi_rdata),
  .s_axi_rresp      (s_axi_rresp),
  .s_axi_rvalid     (s_axi_rvalid),
  .dev_i            (dev_i),
  .zero_drive_o     (zero_drive_o),
  .shutdown_cause_o (shutdown_cause_o),
  .drive_alert_o    (drive_alert_o),
  .timeout_alert_o  (timeout_alert_o)
);

// ==== aesc_host.sv ====
module aesc_host (
  input  wire logic        sys_clk_i,     // clock
  output logic [7:0]       s_axi_awaddr,  // aw addr
  output logic             s_axi_awvalid, // aw valid
  input  wire logic        s_axi_awready, // aw ready
  output logic [31:0]      s_axi_wdata,   // w data
  output logic [3:0]       s_axi_wstrb,   // w strobes
  output logic             s_axi_wvalid,  // w valid
  input  wire logic        s_axi_wready,  // w ready
  input  wire logic [1:0]  s_axi_bresp,   // b resp
  input  wire logic        s_axi_bvalid,  // b valid
  output logic             s_axi_bready,  // b ready
  output logic [7:0]       s_axi_araddr,  // ar addr
  output logic             s_axi_arvalid, // ar valid
  input  wire logic        s_axi_arready, // ar ready
  input  wire logic [31:0] s_axi_rdata,   // r data
  input  wire logic [1:0]  s_axi_rresp,   // r resp
  input  wire logic        s_axi_rvalid,  // r valid
  output logic             s_axi_rready   // r ready
);
  // when set, ready for the answer only after it is seen, so the slave must hold it
  logic slow = 1'b0;
  // byte lanes offered with each write
  logic [3:0] strb = 4'hF;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  task automatic wr_word(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk_i);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= strb;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= !slow;
    forever begin
      @(posedge sys_clk_i);
      // released payload shows the inverse, never a stale copy
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr  <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~d;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
  endtask : wr_word
  task automatic rd_word(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk_i);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= !slow;
    forever begin
      @(posedge sys_clk_i);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr  <= ~a;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
  endtask : rd_word
endmodule : aesc_host

// ==== alert_enable_shutdown_config_test.sv ====
`define CHK(g, e) \
  begin n_compared++; \
    if ((g) !== (e)) begin n_mismatch++; $display("BAD %0t got %h want %h", $time, (g), (e)); end \
  end
module alert_enable_shutdown_config_test
  import aesc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk_i, sys_rst_i, zero_drive_o, drive_alert_o, timeout_alert_o, irq_o;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, shutdown_cause_o;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  aesc_in_t    dev_i;
  int          n_mismatch = 0, n_compared = 0, n_cyc = 0;
  localparam logic [31:0] RST_TAB [16] = '{32'hBF, 32'h1F, 32'h0D, 32'h01, 32'h0, 32'h0, 32'h03, 32'h0,
    32'h0, 32'd600000, 32'd25, 32'd5000, 32'h0, 32'h0, 32'h0, 32'h0};
  localparam logic [7:0]  CL_A [9] = '{8'h1C, 8'h20, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h28, 8'h2C, 8'h2C};
  localparam logic [31:0] CL_W [9] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0, 32'h0, 32'd900000, 32'd200,
    32'd1, 32'd200000, 32'd0};
  localparam logic [31:0] CL_E [9] = '{32'h7F, 32'h7E, 32'h0, 32'h0, 32'd800000, 32'd100, 32'd5,
    32'd120000, 32'd250};
  aesc_top #(.MS_DIV(10)) i_dut (.*);
  aesc_host i_host (.*);
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic acc(input bit w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    logic [31:0] q;
    logic [1:0]  r;
    if (w) i_host.wr_word(a, d, r);
    else i_host.rd_word(a, q, r);
    `CHK(r, er)
    if (!w) `CHK(q, d)
  endtask : acc
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : cyc
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    n_cyc++;
    if (n_cyc == 12000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    sys_rst_i = 1'b1;
    dev_i     = '0;
    cyc(10);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 16; i++) acc(1'b0, 8'(i * 4), RST_TAB[i]);
    for (int i = 0; i < 7; i++) begin
      acc(1'b1, 8'(i * 4), 32'hFFFF_FFFF);
      acc(1'b0, 8'(i * 4), 32'hFFFF_FFFF);
      acc(1'b1, 8'(i * 4), RST_TAB[i]);
    end
    i_host.strb = 4'h2;
    acc(1'b1, PROX_OFS, 32'hFFFF_FFFF);
    i_host.strb = 4'hF;
    acc(1'b0, PROX_OFS, 32'h0000_FF00);
    acc(1'b1, PROX_OFS, 32'h0000_0000);
    for (int i = 0; i < 9; i++) begin
      acc(1'b1, CL_A[i], CL_W[i]);
      acc(1'b0, CL_A[i], CL_E[i]);
    end
    i_host.slow = 1'b1;
    acc(1'b1, SDSTAT_OFS, 32'h1, RESP_SLVERR);
    acc(1'b0, 8'h40, 32'h0, RESP_SLVERR);
    acc(1'b0, 8'h02, 32'h0, RESP_SLVERR);
    i_host.slow = 1'b0;
    acc(1'b1, SDTRIG_OFS, 32'h2);
    dev_i.cond <= 7'h02;
    cyc(4);
    `CHK(shutdown_cause_o, 32'h2)
    `CHK(zero_drive_o, 1'b1)
    `CHK(irq_o, 1'b0)
    acc(1'b0, SDSTAT_OFS, 32'h2);
    acc(1'b0, IRQST_OFS, 32'h4);
    acc(1'b1, IRQMSK_OFS, 32'h4);
    cyc(2);
    `CHK(irq_o, 1'b1)
    dev_i.cond <= 7'h00;
    cyc(4);
    `CHK(shutdown_cause_o, 32'h0)
    `CHK(zero_drive_o, 1'b0)
    acc(1'b1, IRQST_OFS, 32'h4);
    cyc(3);
    `CHK(irq_o, 1'b0)
    acc(1'b1, SDREC_OFS, 32'h2);
    dev_i.cond <= 7'h02;
    cyc(3);
    dev_i.cond <= 7'h00;
    cyc(4);
    `CHK(shutdown_cause_o, 32'h2)
    acc(1'b1, MODE_OFS, 32'h0);
    cyc(2);
    `CHK(shutdown_cause_o, 32'h0)
    acc(1'b1, IRQMSK_OFS, 32'h0);
    acc(1'b1, SDTRIG_OFS, 32'h0);
    dev_i.cond <= 7'h7F;
    cyc(4);
    `CHK(zero_drive_o, 1'b0)
    dev_i.cond         <= 7'h00;
    dev_i.setpoint_upd <= 1'b1;
    acc(1'b1, SDTRIG_OFS, 32'h40);
    acc(1'b1, ELEC_OFS, 32'hFF);
    acc(1'b1, SPTO_OFS, 32'd2);
    dev_i.setpoint_upd <= 1'b0;
    cyc(5);
    dev_i.setpoint_upd <= 1'b1;
    cyc(2);
    `CHK(timeout_alert_o, 1'b0)
    dev_i.setpoint_upd <= 1'b0;
    cyc(40);
    `CHK(timeout_alert_o, 1'b1)
    `CHK(shutdown_cause_o, 32'h40)
    dev_i.setpoint_upd <= 1'b1;
    acc(1'b1, SDTRIG_OFS, 32'h0);
    cyc(3);
    `CHK(timeout_alert_o, 1'b0)
    dev_i.deviation_pct <= 7'd5;
    cyc(2700);
    `CHK(drive_alert_o, 1'b0)
    dev_i.deviation_pct <= 7'd6;
    cyc(2300);
    `CHK(drive_alert_o, 1'b0)
    cyc(300);
    `CHK(drive_alert_o, 1'b1)
    acc(1'b1, SDTRIG_OFS, 32'h1);
    cyc(3);
    `CHK(shutdown_cause_o, 32'h1)
    acc(1'b1, ELEC_OFS, 32'hBE);
    cyc(3);
    `CHK(drive_alert_o, 1'b0)
    `CHK(shutdown_cause_o, 32'h0)
    dev_i.deviation_pct <= 7'd0;
    acc(1'b0, IRQST_OFS, 32'h7);
    acc(1'b1, IRQST_OFS, 32'h7);
    acc(1'b0, IRQST_OFS, 32'h0);
    stop_test();
  end
endmodule : alert_enable_shutdown_config_test
